// >>> hdl/vcd_pkg.sv
package vcd_pkg;
    // Address modifier codes
    localparam logic [5:0] AM_CRCSR     = 6'h2F;
    localparam logic [5:0] AM_BLK_X20   = 6'h20;
    localparam logic [5:0] AM_BLK_X21   = 6'h21;
    localparam logic [5:0] AM_A24_DATA  = 6'h39;
    localparam logic [5:0] AM_A24_SUPD  = 6'h3D;
    localparam logic [5:0] AM_A24_BLT   = 6'h3B;
    localparam logic [5:0] AM_A24_SBLT  = 6'h3F;
    localparam logic [5:0] AM_A32_DATA  = 6'h09;
    localparam logic [5:0] AM_A32_SUPD  = 6'h0D;
    // Block base field of the base register and address slice
    localparam int         BASE_LSB     = 3;
    localparam int         ADDR_BLK_LSB = 19;
    localparam int         ADDR_BLK_MSB = 23;
    localparam logic [4:0] REGION_RSVD  = 5'h00;
    // Fixed locations inside the configuration block
    localparam logic [18:0] OFS_BASE_REG  = 19'h7FFFF;
    localparam logic [18:0] OFS_ROM_END   = 19'h00FFF;
    localparam logic [18:0] OFS_CSR_RSVD  = 19'h7FC03;
    localparam logic [18:0] OFS_UROM_BEG  = 19'h00083;
    localparam logic [18:0] OFS_UROM_END  = 19'h0008F;
    localparam logic [18:0] OFS_CONFIG_RAM_AREA_BEG  = 19'h0009B;
    localparam logic [18:0] OFS_CONFIG_RAM_AREA_END  = 19'h000A7;
    localparam logic [18:0] OFS_UCSR_BEG  = 19'h000B3;
    localparam logic [18:0] OFS_UCSR_END  = 19'h000BF;
    localparam logic [7:0]  BASE_RST      = 8'h00;
    // Transfer widths
    typedef enum logic [2:0] {
        VCD_W_NONE = 3'h0,
        VCD_W_B_EVEN = 3'h1,
        VCD_W_B_ODD = 3'h2,
        VCD_W_D16 = 3'h3,
        VCD_W_D32 = 3'h4
    } vcd_width_t;
    typedef enum logic [1:0] {
        VCD_SP_NONE = 2'h0,
        VCD_SP_CRCSR = 2'h1,
        VCD_SP_DATA = 2'h3
    } vcd_space_t;
endpackage

// >>> hdl/vcd_slave_decode.sv
`timescale 1ns/1ps
// What this block does
// RULE1: A 32-bit slave also takes 16-bit and even or odd byte transfers.
// RULE2: A 16-bit slave also takes even or odd byte transfers.
// RULE3: Odd-byte-only mode is optional for wider slaves; here it is accepted.
// RULE4: 64-bit block capable slaves also take 32, 16 and byte transfers.
// RULE5: Configuration block is 512 kB, reached in 24-bit with modifier 2F.
// RULE6: Space is chosen by modifier code alone, never by address overlap.
// RULE7: Base register picks one of 31 regions; region zero is never decoded.
// RULE8: Modifiers 20 and 21 are block transfers qualified by extended code.
// RULE9: Only one data space is defined in this slave.
// RULE10: Without 24-bit data space, plain 24-bit codes may reach the block.
// RULE11: Base register is one byte at the top address of the block.
// RULE12: Base register loads itself from the slot geographic address.
// RULE13: Base bits 7..3 compare with address bits 23..19.
// RULE14: Block base is the slot address shifted left by 19.
// RULE15: Without slot pins, a strap value stands in for the slot address.
// RULE16: User ROM and user control areas are found through fixed pointers.
// RULE17: A second pointer pair delimits the configuration RAM area.
// RULE18: Optional areas lie between 0x00FFF and 0x7FC03.
// RULE19: Legacy 32-bit space compares a switch byte with address 31..24.
// RULE20: No acknowledge or data drive for an undecoded cycle.
module vcd_slave_decode
    import vcd_pkg::*;
#(
    parameter int         DATA_W      = 32,
    parameter logic       A24_DATA_EN = 1'b0,
    parameter logic [18:0] UROM_BEG   = 19'h01000,
    parameter logic [18:0] UROM_END   = 19'h01FFF,
    parameter logic [18:0] CONFIG_RAM_AREA_BEG   = 19'h02000,
    parameter logic [18:0] CONFIG_RAM_AREA_END   = 19'h02FFF,
    parameter logic [18:0] UCSR_BEG   = 19'h03000,
    parameter logic [18:0] UCSR_END   = 19'h03FFF
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    input  wire logic [4:0]  SLOT_GEO_ADDRESS_N,
    input  wire logic        GEO_PINS_PRESENT,
    input  wire logic [4:0]  SLOT_STRAP,
    input  wire logic [7:0]  SPACE_SWITCH,
    input  wire logic        ADDR_STROBE,
    input  wire logic [31:0] ADDR,
    input  wire logic [5:0]  AM,
    input  wire logic [7:0]  XAM,
    input  wire logic        LWORD_N,
    input  wire logic        DS0_N,
    input  wire logic        DS1_N,
    input  wire logic        WRITE_N,
    input  wire logic [7:0]  WDATA,
    output logic             SEL_CRCSR,
    output logic             SEL_DATA,
    output logic             SEL_BLOCK,
    output logic             SEL_UROM,
    output logic             SEL_CONFIG_RAM_AREA,
    output logic             SEL_UCSR,
    output logic [2:0]       WIDTH,
    output logic [18:0]      OFFSET,
    output logic             ACK,
    output logic [7:0]       RDATA,
    output logic             RDATA_OE,
    output logic [7:0]       BLOCK_BASE
);
    typedef struct packed {
        logic [7:0]  base;
        logic        loaded;
        logic        crcsr;
        logic        data;
        logic        blk;
        logic        urom;
        logic        config_ram_area;
        logic        ucsr;
        vcd_width_t  width;
        logic [18:0] ofs;
        logic        ack;
        logic [7:0]  rdata;
        logic        oe;
    } vcd_state_t;

    vcd_state_t st_q;
    vcd_state_t st_d;

    // Pointer byte lookup; pointers are 3 bytes, MSB at the lowest slot
    function automatic logic [7:0] ptr_byte(input logic [18:0] v,
                                            input logic [1:0] idx);
        logic [23:0] w;
        w = {5'h00, v};
        unique case (idx)
            2'd0:    ptr_byte = w[23:16];
            2'd1:    ptr_byte = w[15:8];
            default: ptr_byte = w[7:0];
        endcase
    endfunction

    // Byte index inside a pointer triple, counted from its first slot;
    // the triples start at different word phases, so the low offset bits
    // alone cannot tell which byte is wanted
    function automatic logic [1:0] ptr_idx(input logic [18:0] o,
                                           input logic [18:0] start);
        logic [18:0] d;
        d = o - start;
        ptr_idx = d[3:2];
    endfunction

    // Selects which pointer triple (if any) covers a given offset
    function automatic logic in_ptr(input logic [18:0] o,
                                    input logic [18:0] start);
        in_ptr = (o >= start) && (o <= start + 19'd8) && (o[1:0] == 2'b11);
    endfunction

    // Data width from strobes and the long-word line
    function automatic vcd_width_t dec_width(input logic lw_n,
                                             input logic d0_n,
                                             input logic d1_n,
                                             input logic a1);
        if (!d0_n && !d1_n && !lw_n && !a1)
            dec_width = VCD_W_D32;                   // see RULE1
        else if (!d0_n && !d1_n && lw_n)
            dec_width = VCD_W_D16;                   // see RULE2
        else if (!d1_n && d0_n && lw_n)
            dec_width = VCD_W_B_EVEN;
        else if (!d0_n && d1_n && lw_n)
            dec_width = VCD_W_B_ODD;                 // see RULE3
        else
            dec_width = VCD_W_NONE;
    endfunction

    logic [4:0]  slot;
    logic        am_a24;
    logic        am_a32;
    logic        crcsr_hit;
    logic        data_hit;
    logic        blk_hit;
    vcd_width_t  w;
    logic [18:0] o;

    // Slot address: pins are active low; strap stands in on old backplanes
    assign slot = GEO_PINS_PRESENT ? ~SLOT_GEO_ADDRESS_N
                                   : SLOT_STRAP;            // see RULE15
    assign am_a24 = (AM == AM_A24_DATA) || (AM == AM_A24_SUPD)
                 || (AM == AM_A24_BLT) || (AM == AM_A24_SBLT);
    assign am_a32 = (AM == AM_A32_DATA) || (AM == AM_A32_SUPD);
    assign o      = ADDR[18:0];
    assign w      = dec_width(LWORD_N, DS0_N, DS1_N, ADDR[1]);

    // Space decode by modifier first, then by address; region zero never hits
    always_comb begin
        crcsr_hit = 1'b0;
        if ((AM == AM_CRCSR) || (!A24_DATA_EN && am_a24))  // see RULE5
            crcsr_hit = st_q.loaded                         // see RULE10
                && (st_q.base[7:BASE_LSB] != REGION_RSVD)   // see RULE7
                && (ADDR[ADDR_BLK_MSB:ADDR_BLK_LSB]
                    == st_q.base[7:BASE_LSB]);              // see RULE13
        // Single legacy data space, selected by modifier and switch byte  see RULE6
        data_hit = am_a32 && (ADDR[31:24] == SPACE_SWITCH); // see RULE19
        if (A24_DATA_EN && am_a24)
            data_hit = 1'b0;                                // see RULE9
        blk_hit = ((AM == AM_BLK_X20) || (AM == AM_BLK_X21))
               && (ADDR[31:24] == SPACE_SWITCH)
               && (XAM != 8'h00);                           // see RULE8
    end

    // Next state: base load, cycle decode, acknowledge and read data
    always_comb begin
        st_d       = st_q;
        st_d.ack   = 1'b0;
        st_d.oe    = 1'b0;
        // Base register loads once from the slot address on the first edge after reset
        if (!st_q.loaded) begin
            st_d.base   = {slot, 3'b000};                   // see RULE14
            st_d.loaded = 1'b1;                             // see RULE12
        end
        if (ADDR_STROBE) begin
            st_d.crcsr = crcsr_hit;
            st_d.data  = data_hit;
            st_d.blk   = blk_hit;
            st_d.width = w;
            st_d.ofs   = o;
            // An area set outside the free part is never selected
            st_d.urom  = crcsr_hit && o >= UROM_BEG && o <= UROM_END
                      && UROM_BEG > OFS_ROM_END
                      && UROM_END < OFS_CSR_RSVD;           // see RULE16
            st_d.config_ram_area  = crcsr_hit && o >= CONFIG_RAM_AREA_BEG && o <= CONFIG_RAM_AREA_END
                      && CONFIG_RAM_AREA_BEG > OFS_ROM_END
                      && CONFIG_RAM_AREA_END < OFS_CSR_RSVD;           // see RULE17
            st_d.ucsr  = crcsr_hit && o >= UCSR_BEG && o <= UCSR_END
                      && UCSR_BEG > OFS_ROM_END
                      && UCSR_END < OFS_CSR_RSVD;           // see RULE18
            // Acknowledge only a decoded cycle of a legal width
            st_d.ack   = (crcsr_hit || data_hit || blk_hit)
                      && (w != VCD_W_NONE);                 // see RULE20
            st_d.rdata = 8'h00;
            if (crcsr_hit && w != VCD_W_NONE) begin
                if (o == OFS_BASE_REG) begin
                    st_d.rdata = st_q.base;                 // see RULE11
                    if (!WRITE_N)
                        st_d.base = WDATA;
                end else if (in_ptr(o, OFS_UROM_BEG))
                    st_d.rdata = ptr_byte(UROM_BEG, ptr_idx(o, OFS_UROM_BEG));
                else if (in_ptr(o, OFS_UROM_END))
                    st_d.rdata = ptr_byte(UROM_END, ptr_idx(o, OFS_UROM_END));
                else if (in_ptr(o, OFS_CONFIG_RAM_AREA_BEG))
                    st_d.rdata = ptr_byte(CONFIG_RAM_AREA_BEG, ptr_idx(o, OFS_CONFIG_RAM_AREA_BEG));
                else if (in_ptr(o, OFS_CONFIG_RAM_AREA_END))
                    st_d.rdata = ptr_byte(CONFIG_RAM_AREA_END, ptr_idx(o, OFS_CONFIG_RAM_AREA_END));
                else if (in_ptr(o, OFS_UCSR_BEG))
                    st_d.rdata = ptr_byte(UCSR_BEG, ptr_idx(o, OFS_UCSR_BEG));
                else if (in_ptr(o, OFS_UCSR_END))
                    st_d.rdata = ptr_byte(UCSR_END, ptr_idx(o, OFS_UCSR_END));
                st_d.oe = WRITE_N;                          // see RULE20
            end else if (data_hit || blk_hit)
                st_d.oe = WRITE_N && (w != VCD_W_NONE);     // see RULE4
        end else begin
            st_d.crcsr = 1'b0;
            st_d.data  = 1'b0;
            st_d.blk   = 1'b0;
            st_d.urom  = 1'b0;
            st_d.config_ram_area  = 1'b0;
            st_d.ucsr  = 1'b0;
            st_d.width = VCD_W_NONE;
        end
    end

    // Register the whole state; reset clears the base to BASE_RST, the next edge loads the slot
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            st_q        <= '0;
            st_q.base   <= BASE_RST;
            st_q.width  <= VCD_W_NONE;
        end else begin
            st_q <= st_d;
        end
    end

    assign SEL_CRCSR  = st_q.crcsr;
    assign SEL_DATA   = st_q.data;
    assign SEL_BLOCK  = st_q.blk;
    assign SEL_UROM   = st_q.urom;
    assign SEL_CONFIG_RAM_AREA   = st_q.config_ram_area;
    assign SEL_UCSR   = st_q.ucsr;
    assign WIDTH      = st_q.width;
    assign OFFSET     = st_q.ofs;
    assign ACK        = st_q.ack;
    assign RDATA      = st_q.rdata;
    assign RDATA_OE   = st_q.oe;
    assign BLOCK_BASE = st_q.base;

    // Checks on the decode
    AST_NO_ACK_UNDECODED: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        ACK |-> (SEL_CRCSR || SEL_DATA || SEL_BLOCK)) // see RULE20
        else $error("ack without decoded space");
    AST_OE_NEEDS_ACK: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        RDATA_OE |-> ACK) // see RULE20
        else $error("data driven without ack");
    AST_REGION_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        SEL_CRCSR |-> BLOCK_BASE[7:3] != 5'h00) // see RULE7
        else $error("region zero decoded");
    AST_BASE_MATCH: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (ADDR_STROBE && crcsr_hit) |=>
            SEL_CRCSR && ($past(ADDR[23:19]) == BLOCK_BASE[7:3]
                           || $past(!WRITE_N))) // see RULE13
        else $error("block base mismatch");
    AST_AM_ONLY: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        SEL_CRCSR |-> !SEL_DATA && !SEL_BLOCK) // see RULE6
        else $error("two spaces selected");
    AST_BASE_LOAD: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        $rose(st_q.loaded) |-> BLOCK_BASE == {$past(slot), 3'b000}) // see RULE14
        else $error("base not loaded from slot");
    AST_D32_WIDTH: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (ADDR_STROBE && !LWORD_N && !DS0_N && !DS1_N && !ADDR[1])
            |=> WIDTH == 3'h4) // see RULE1
        else $error("32-bit width not decoded");
    AST_BYTE_WIDTH: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (ADDR_STROBE && LWORD_N && (DS0_N != DS1_N))
            |=> WIDTH inside {3'h1, 3'h2}) // see RULE2
        else $error("byte width not decoded");
    // Sixteen-bit cycles keep their width
    AST_D16_WIDTH: assert property ( // see RULE2
        @(posedge SYS_CLK) disable iff (!RST_B)
        (ADDR_STROBE && LWORD_N && !DS0_N && !DS1_N)
            |=> WIDTH == 3'h3)
        else $error("16-bit width not decoded");
    // Odd byte alone is taken, not refused
    AST_ODD_BYTE: assert property ( // see RULE3
        @(posedge SYS_CLK) disable iff (!RST_B)
        (ADDR_STROBE && LWORD_N && !DS0_N && DS1_N)
            |=> WIDTH == 3'h2)
        else $error("odd byte width not decoded");
    // A legal configuration cycle in our block is answered
    AST_CRCSR_ANSWER: assert property ( // see RULE5
        @(posedge SYS_CLK) disable iff (!RST_B)
        (ADDR_STROBE && AM == AM_CRCSR && crcsr_hit && w != VCD_W_NONE)
            |=> ACK && SEL_CRCSR)
        else $error("configuration cycle not answered");
    // Legacy data codes never reach the configuration block
    AST_DATA_NOT_CRCSR: assert property ( // see RULE6
        @(posedge SYS_CLK) disable iff (!RST_B)
        (ADDR_STROBE && (AM == AM_A32_DATA || AM == AM_A32_SUPD))
            |=> !SEL_CRCSR)
        else $error("data code reached configuration block");
    // Block codes need a nonzero extended code
    AST_BLOCK_XAM: assert property ( // see RULE8
        @(posedge SYS_CLK) disable iff (!RST_B)
        SEL_BLOCK |-> $past(XAM) != 8'h00)
        else $error("block cycle without extended code");
    // Base register reads back at the top byte
    AST_BASE_READ: assert property ( // see RULE11
        @(posedge SYS_CLK) disable iff (!RST_B)
        (ADDR_STROBE && crcsr_hit && o == OFS_BASE_REG && WRITE_N
            && w != VCD_W_NONE) |=> RDATA == $past(BLOCK_BASE))
        else $error("base register read wrong");
    // Strap value stands in when pins are absent
    AST_STRAP_LOAD: assert property ( // see RULE15
        @(posedge SYS_CLK) disable iff (!RST_B)
        ($rose(st_q.loaded) && !$past(GEO_PINS_PRESENT))
            |-> BLOCK_BASE[7:3] == $past(SLOT_STRAP))
        else $error("base not loaded from strap");
    // Optional areas stay inside the free part of the block
    AST_AREA_BOUNDS: assert property ( // see RULE18
        @(posedge SYS_CLK) disable iff (!RST_B)
        (SEL_UROM || SEL_CONFIG_RAM_AREA || SEL_UCSR)
            |-> OFFSET > OFS_ROM_END && OFFSET < OFS_CSR_RSVD)
        else $error("area selected outside free space");
    // Legacy space only at the switch byte
    AST_DATA_SWITCH: assert property ( // see RULE19
        @(posedge SYS_CLK) disable iff (!RST_B)
        SEL_DATA |-> $past(ADDR[31:24]) == SPACE_SWITCH)
        else $error("data space outside switch setting");
    // Nothing is selected without a strobed cycle
    AST_SEL_NEEDS_STROBE: assert property ( // see RULE20
        @(posedge SYS_CLK) disable iff (!RST_B)
        (SEL_CRCSR || SEL_DATA || SEL_BLOCK) |-> $past(ADDR_STROBE))
        else $error("space selected without strobe");
    // Writes never see our data drivers on
    AST_NO_WRITE_DRIVE: assert property ( // see RULE20
        @(posedge SYS_CLK) disable iff (!RST_B)
        (ADDR_STROBE && !WRITE_N) |=> !RDATA_OE)
        else $error("data driven on a write");
endmodule

// >>> tb/vcd_master_model.sv
`timescale 1ns/1ps
// Bus master stand-in: one address cycle per call
module vcd_master_model (
    input  wire logic        clk,
    output logic             strobe,
    output logic [31:0]      addr,
    output logic [5:0]       am,
    output logic [7:0]       xam,
    output logic [2:0]       strb,
    output logic             write_n,
    output logic [7:0]       wdata
);
    // Idle bus: strobes pulled high, write line high, other lines never keep the last value
    initial begin
        strobe = 1'b0;
        addr = 32'h0000_0000;
        am = 6'h00;
        xam = 8'h00;
        strb = 3'h7;
        write_n = 1'b1;
        wdata = 8'h00;
    end
    // Drive after an edge, hold one sampling edge, then release
    task automatic bus_cycle(input logic [5:0] am_v, input logic [31:0] a_v,
                             input logic [7:0] x_v, input logic [2:0] s_v,
                             input logic w_v, input logic [7:0] d_v);
        @(posedge clk);
        strobe <= 1'b1;
        am <= am_v;
        xam <= x_v;
        addr <= a_v;
        strb <= s_v;
        write_n <= w_v;
        wdata <= d_v;
        @(posedge clk);
        strobe <= 1'b0;
        strb <= 3'h7;
        write_n <= 1'b1;
        addr <= ~a_v;
        am <= ~am_v;
        xam <= ~x_v;
        wdata <= ~d_v;
    endtask
endmodule

// >>> tb/vme_slave_crcsr_decode_bench.sv
`timescale 1ns/1ps
module vme_slave_crcsr_decode_bench;
    import vcd_pkg::*;
    typedef struct packed {
        logic [5:0]  am;
        logic [31:0] addr;
        logic [7:0]  xam;
        logic [2:0]  strb;
        logic [2:0]  sel;
        logic [2:0]  width;
        logic        ack;
    } vcd_row_t;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        geo_en = 1'b1;
    logic [4:0]  strap = 5'h00;
    logic [4:0]  slot_n = 5'h1A;
    logic [7:0]  sw = 8'hA5;
    logic        strobe, write_n, ack, rdata_oe;
    logic        sel_crcsr, sel_data, sel_block, sel_urom, sel_config_ram_area, sel_ucsr;
    logic [31:0] addr;
    logic [5:0]  am;
    logic [7:0]  xam, wdata, rdata, block_base;
    logic [2:0]  strb, width;
    logic [18:0] offset;
    int          n_fail = 0;
    int          tests_run = 0;
    vcd_row_t    rows [14];

    // Slot pins read slot 5, so the block sits at 0x280000
    vcd_slave_decode uut (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .SLOT_GEO_ADDRESS_N(slot_n),
        .GEO_PINS_PRESENT(geo_en), .SLOT_STRAP(strap), .SPACE_SWITCH(sw),
        .ADDR_STROBE(strobe), .ADDR(addr), .AM(am), .XAM(xam),
        .LWORD_N(strb[2]), .DS1_N(strb[1]), .DS0_N(strb[0]),
        .WRITE_N(write_n), .WDATA(wdata), .SEL_CRCSR(sel_crcsr),
        .SEL_DATA(sel_data), .SEL_BLOCK(sel_block), .SEL_UROM(sel_urom),
        .SEL_CONFIG_RAM_AREA(sel_config_ram_area), .SEL_UCSR(sel_ucsr), .WIDTH(width),
        .OFFSET(offset), .ACK(ack), .RDATA(rdata), .RDATA_OE(rdata_oe),
        .BLOCK_BASE(block_base)
    );
    vcd_master_model mdl (
        .clk(sys_clk), .strobe(strobe), .addr(addr), .am(am), .xam(xam),
        .strb(strb), .write_n(write_n), .wdata(wdata)
    );

    // Clock at 20 MHz
    always #25 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Outputs read zero in reset; base loads on the first edge after it
    task automatic do_reset(input logic g, input logic [4:0] s,
                            input logic [7:0] base);
        rst_b <= 1'b0;
        geo_en <= g;
        strap <= s;
        repeat (6) @(posedge sys_clk);
        #1;
        check({ack, rdata_oe, block_base}, 10'h000);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        #1;
        check(block_base, base);
    endtask

    // Read cycle, answer sampled 1 ns after the edge that takes in the strobe
    task automatic rd(input logic [5:0] m, input logic [31:0] a,
                      input logic [2:0] s);
        mdl.bus_cycle(m, a, 8'h00, s, 1'b1, 8'h00);
        #1;
    endtask

    initial begin
        // strb is {lword_n, ds1_n, ds0_n}; sel is {crcsr, data, block}
        rows = '{
            '{6'h2F, 32'h002F_FFFF, 8'h00, 3'h6, 3'h4, 3'h2, 1'b1},
            '{6'h2F, 32'h002F_FFFE, 8'h00, 3'h5, 3'h4, 3'h1, 1'b1},
            '{6'h2F, 32'h0028_0000, 8'h00, 3'h4, 3'h4, 3'h3, 1'b1},
            '{6'h2F, 32'h0028_0000, 8'h00, 3'h0, 3'h4, 3'h4, 1'b1},
            '{6'h2F, 32'h0030_0001, 8'h00, 3'h6, 3'h0, 3'h0, 1'b0},
            '{6'h39, 32'h002F_FFFF, 8'h00, 3'h6, 3'h4, 3'h2, 1'b1},
            '{6'h3D, 32'h002F_FFFF, 8'h00, 3'h6, 3'h4, 3'h2, 1'b1},
            '{6'h09, 32'hA500_1000, 8'h00, 3'h0, 3'h2, 3'h4, 1'b1},
            '{6'h0D, 32'hA52F_FFFF, 8'h00, 3'h6, 3'h2, 3'h2, 1'b1},
            '{6'h09, 32'hA600_1000, 8'h00, 3'h0, 3'h0, 3'h0, 1'b0},
            '{6'h20, 32'hA500_1000, 8'h01, 3'h0, 3'h1, 3'h4, 1'b1},
            '{6'h21, 32'hA500_1000, 8'h00, 3'h0, 3'h0, 3'h0, 1'b0},
            '{6'h2A, 32'h002F_FFFF, 8'h00, 3'h6, 3'h0, 3'h0, 1'b0},
            '{6'h2F, 32'h002F_FFFF, 8'h00, 3'h2, 3'h0, 3'h0, 1'b0}
        };
        do_reset(1'b1, 5'h00, 8'h28);
        // Table of decoded and refused cycles
        for (int i = 0; i < 14; i++) begin
            mdl.bus_cycle(rows[i].am, rows[i].addr, rows[i].xam,
                          rows[i].strb, 1'b1, 8'h00);
            #1;
            check(ack, rows[i].ack);
            check(rdata_oe, rows[i].ack);
            if (rows[i].ack) begin
                check({sel_crcsr, sel_data, sel_block}, rows[i].sel);
                check(width, rows[i].width);
                check(offset, rows[i].addr[18:0]);
            end
        end
        // Base register readable at the top byte of the block
        rd(6'h2F, 32'h002F_FFFF, 3'h6);
        check(rdata, 8'h28);
        // Pointer middle bytes and the areas they delimit
        for (int i = 0; i < 3; i++) begin
            rd(6'h2F, 32'h0028_0087 + 32'(i * 24), 3'h6);
            check(rdata, 32'(i + 1) << 4);
            rd(6'h2F, 32'h0028_1001 + 32'(i * 4096), 3'h6);
            check({sel_urom, sel_config_ram_area, sel_ucsr}, 3'h4 >> i);
        end
        // A write moves the block to slot 6, data not driven on writes
        mdl.bus_cycle(6'h2F, 32'h002F_FFFF, 8'h00, 3'h6, 1'b0, 8'h30);
        #1;
        check({ack, rdata_oe}, 2'h2);
        rd(6'h2F, 32'h0037_FFFF, 3'h6);
        check({ack, rdata}, 9'h130);
        // Strap to region zero: never decoded; strap to slot 3: decoded
        do_reset(1'b0, 5'h00, 8'h00);
        rd(6'h2F, 32'h0007_FFFF, 3'h6);
        check(ack, 1'b0);
        do_reset(1'b0, 5'h03, 8'h18);
        rd(6'h2F, 32'h001F_FFFF, 3'h6);
        check({ack, rdata}, 9'h118);
        test_done();
    end
endmodule
